// *** common/pad_integration_pkg.sv ***
/*
 Shared constants and types of the pad and external interrupt unit.
 Assumes a 32-bit APB slave port decoding a 16 KB window.
*/
package pad_integration_pkg;
   // Sizes of the pad and interrupt arrays
   localparam int NUM_PADS = 123;
   localparam int REDUCED_PADS = 79;
   localparam int NUM_EXT_IRQ_INPUT = 16;
   localparam int NUM_PORTS = 8;
   localparam int PORT_W = 16;
   localparam int EXT_IRQ_INPUT_PER_VECTOR = 8;
   localparam int ADDR_W = 14;
   // Pads without an output driver
   localparam int IN_ONLY_A_LO = 20;
   localparam int IN_ONLY_A_HI = 25;
   localparam int IN_ONLY_B_LO = 48;
   localparam int IN_ONLY_B_HI = 59;
   // Pad setup slots that the write lock guards
   localparam int LOCK_A_LO = 0;
   localparam int LOCK_A_HI = 19;
   localparam int LOCK_B_LO = 34;
   localparam int LOCK_B_HI = 47;
   // Register byte offsets
   localparam logic [13:0] OFS_ID_ONE = 14'h0004;
   localparam logic [13:0] OFS_ID_TWO = 14'h0008;
   localparam logic [13:0] OFS_FLAGS = 14'h0014;
   localparam logic [13:0] OFS_REQ_EN = 14'h0018;
   localparam logic [13:0] OFS_RISE_EN = 14'h0028;
   localparam logic [13:0] OFS_FALL_EN = 14'h002C;
   localparam logic [13:0] OFS_FILT_EN = 14'h0030;
   localparam logic [13:0] OFS_SETUP_LO = 14'h0040;
   localparam logic [13:0] OFS_SETUP_HI = 14'h0134;
   localparam logic [13:0] OFS_SEL_LO = 14'h0500;
   localparam logic [13:0] OFS_SEL_HI = 14'h051C;
   localparam logic [13:0] OFS_OUTV_LO = 14'h0600;
   localparam logic [13:0] OFS_OUTV_HI = 14'h0678;
   localparam logic [13:0] OFS_INV_LO = 14'h0800;
   localparam logic [13:0] OFS_INV_HI = 14'h0878;
   localparam logic [13:0] OFS_PORTO_LO = 14'h0C00;
   localparam logic [13:0] OFS_PORTO_HI = 14'h0C0C;
   localparam logic [13:0] OFS_PORTI_LO = 14'h0C40;
   localparam logic [13:0] OFS_PORTI_HI = 14'h0C4C;
   localparam logic [13:0] OFS_MASKED_LO = 14'h0C80;
   localparam logic [13:0] OFS_MASKED_HI = 14'h0C9C;
   localparam logic [13:0] OFS_LIMIT_LO = 14'h1000;
   localparam logic [13:0] OFS_LIMIT_HI = 14'h103C;
   localparam logic [13:0] OFS_PRESC = 14'h1080;
   // Reset values
   localparam logic [15:0] SETUP_RST = 16'h0000;
   localparam logic [15:0] EXT_IRQ_INPUT_RST = 16'h0000;
   localparam logic [31:0] SEL_RST = 32'h00000000;
   localparam logic [3:0] LIMIT_RST = 4'h0;
   localparam logic [3:0] PRESC_RST = 4'h0;
   // Function select value that hands the pad to the output data bit
   localparam logic [1:0] PA_GPIO = 2'h0;
   // Pad setup layout, most significant field first
   typedef struct packed {
      logic rsv0;
      logic smc;
      logic apc;
      logic rsv1;
      logic [1:0] pa;
      logic obe;
      logic ibe;
      logic [1:0] rsv2;
      logic ode;
      logic [1:0] rsv3;
      logic src;
      logic wpe;
      logic wps;
   } pad_setup_t;
endpackage : pad_integration_pkg

// *** verification/pad_integration_sva.sv ***
/*
 Port assertions for the pad and interrupt unit.
 Assumes one ref_clk domain and rstn active low.
*/
`timescale 1ns/10ps
`default_nettype none
module pad_integration_sva (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pad_integration_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic reg_lock,
   input wire logic [pad_integration_pkg::NUM_PADS-1:0] pad_level_out,
   input wire logic [pad_integration_pkg::NUM_PADS-1:0] pad_drive_en,
   input wire logic [1:0] irq_vector
);
   import pad_integration_pkg::*;
   logic [31:0] wd_q;
   logic [15:0] po_q;
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // Last write data and port 0 outputs, for masked and word writes
   always_ff @(posedge ref_clk) begin
      wd_q <= pwdata;
      po_q <= pad_level_out[15:0];
   end
   // Access phase at one address, and a full-word write there
   sequence s_acc(logic [13:0] a);
      psel && penable && paddr == a;
   endsequence
   sequence s_wr(logic [13:0] a);
      s_acc(a) ##0 (pwrite && pstrb == 4'hF);
   endsequence
   property p_err_hole;
      s_acc(14'h0000) |-> pslverr;
   endproperty
   a_err_hole: assert property (p_err_hole) else $error("no error on reserved hole");
   property p_no_err_flags;
      s_acc(OFS_FLAGS) |-> !pslverr;
   endproperty
   a_no_err_flags: assert property (p_no_err_flags) else $error("error on mapped reg");
   property p_ready;
      psel && !penable ##1 psel && penable |-> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("access not answered");
   property p_in_only;
      pad_drive_en[IN_ONLY_A_HI:IN_ONLY_A_LO] == '0 && pad_drive_en[IN_ONLY_B_HI:IN_ONLY_B_LO] == '0;
   endproperty
   a_in_only: assert property (p_in_only) else $error("input-only pad driven");
   property p_pad_write;
      s_wr(OFS_OUTV_LO) |=> pad_level_out[3:0] == {wd_q[24], wd_q[16], wd_q[8], wd_q[0]};
   endproperty
   a_pad_write: assert property (p_pad_write) else $error("pad data byte lanes wrong");
   property p_port_write;
      s_wr(OFS_PORTO_LO) |=> pad_level_out[31:0] == wd_q;
   endproperty
   a_port_write: assert property (p_port_write) else $error("port write wrong");
   property p_masked;
      s_wr(OFS_MASKED_LO) |=>
         pad_level_out[15:0] == ((wd_q[31:16] & wd_q[15:0]) | (~wd_q[31:16] & po_q));
   endproperty
   a_masked: assert property (p_masked) else $error("masked port write wrong");
   property p_lock;
      reg_lock ##0 s_wr(OFS_SETUP_LO) |=> $stable(pad_drive_en[1:0]);
   endproperty
   a_lock: assert property (p_lock) else $error("locked pad setup changed");
   property p_irq_mask;
      s_wr(OFS_REQ_EN) ##0 (!reg_lock && pwdata[15:0] == 16'h0000) |=> irq_vector == 2'b00;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq while disabled");
   property p_flag_keep;
      s_wr(OFS_FLAGS) ##0 (pwdata == 32'h00000000 && irq_vector[0]) |=> irq_vector[0];
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("zero write cleared flag");
   property p_reset_clear;
      $rose(rstn) |-> pad_drive_en == '0 && irq_vector == 2'b00;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("outputs not reset");
endmodule : pad_integration_sva
bind pad_integration_unit pad_integration_sva u_sva (.ref_clk(ref_clk), .rstn(rstn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .reg_lock(reg_lock),
   .pad_level_out(pad_level_out), .pad_drive_en(pad_drive_en), .irq_vector(irq_vector));
`default_nettype wire

// *** verification/pad_integration_unit_bench.sv ***
/*
 Self-checking bench of the pad and interrupt unit.
 Assumes zero-wait APB and a pad model on the far side.
*/
`timescale 1ns/10ps
`default_nettype none
module pad_integration_unit_bench;
   import pad_integration_pkg::*;
   localparam logic [31:0] ID_A = 32'h00000A11; // Arbitrary identity value
   logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, reg_lock, er;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [NUM_PADS-1:0] pad_level_in, pad_level_out, pad_drive_en, ext_level, short_low;
   logic [NUM_EXT_IRQ_INPUT-1:0] ext_irq_input;
   logic [1:0] irq_vector;
   logic [13:0] holes [4] = '{14'h0000, 14'h000C, 14'h0C10, 14'h1084};
   int num_errors = 0;
   int n_compared = 0;
   pad_integration_unit #(.ID_ONE(ID_A)) DUT (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .reg_lock(reg_lock),
      .pad_level_in(pad_level_in), .pad_level_out(pad_level_out),
      .pad_drive_en(pad_drive_en), .ext_irq_input(ext_irq_input), .irq_vector(irq_vector));
   pad_world_model u_pads (.pad_level_out(pad_level_out), .pad_drive_en(pad_drive_en),
      .ext_level(ext_level), .short_low(short_low), .pad_level_in(pad_level_in));
   // Free-running clock
   always #5 ref_clk = ~ref_clk;
   task automatic stop_test();
      $display("compared %0d mismatched %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // One APB transfer; read data and error taken at the pready edge
   task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         num_errors++;
         stop_test();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [13:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      @(negedge ref_clk);
   endtask : wr
   task automatic rdchk(input string nm, input logic [13:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, exp, rd);
   endtask : rdchk
   task automatic wait_irq(input logic [1:0] e);
      int n;
      n = 0;
      while (irq_vector !== e && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      chk("irq_vector", {30'h0, e}, {30'h0, irq_vector});
      if (irq_vector !== e) stop_test();
   endtask : wait_irq
   task automatic t_regs();
      rdchk("id_one", OFS_ID_ONE, ID_A);
      wr(OFS_ID_ONE, 32'h0);
      rdchk("id_one_ro", OFS_ID_ONE, ID_A);
      rdchk("flags", OFS_FLAGS, 32'h0);
      chk("flags_err", 32'h0, {31'h0, er});
      foreach (holes[i]) begin
         apb(1'b0, holes[i], 32'h0);
         chk("hole_err", 32'h1, {31'h0, er});
      end
      $display("test regs done");
   endtask : t_regs
   task automatic t_pads();
      wr(OFS_SETUP_LO, 32'h03000300);
      wr(OFS_SETUP_LO + 14'h0008, 32'h00000100);
      wr(OFS_SETUP_LO + 14'h0028, 32'h02000200);
      wr(OFS_OUTV_LO, 32'h00000001);
      chk("drive_en", 32'h3, {30'h0, pad_drive_en[1:0]});
      chk("out", 32'h1, {30'h0, pad_level_out[1:0]});
      chk("in_only", 32'h0, {30'h0, pad_drive_en[21:20]});
      repeat (6) @(posedge ref_clk);
      rdchk("in_word0", OFS_INV_LO, 32'h00000001);
      rdchk("in_word1", OFS_INV_LO + 14'h0004, 32'h00000001);
      short_low[0] <= 1'b1;
      repeat (6) @(posedge ref_clk);
      rdchk("in_short", OFS_INV_LO, 32'h00000000);
      short_low[0] <= 1'b0;
      $display("test pads done");
   endtask : t_pads
   task automatic t_port();
      wr(OFS_PORTO_LO, 32'hA5A55A5A);
      chk("port_out", 32'hA5A55A5A, pad_level_out[31:0]);
      wr(OFS_MASKED_LO, 32'h00FF1234);
      wr(OFS_MASKED_LO + 14'h0004, 32'hFF000000);
      rdchk("port_rd", OFS_PORTO_LO, 32'h00A55A34);
      $display("test port done");
   endtask : t_port
   task automatic t_lock();
      @(posedge ref_clk);
      reg_lock <= 1'b1;
      wr(OFS_SETUP_LO, 32'h0);
      chk("locked_setup", 32'h3, {30'h0, pad_drive_en[1:0]});
      wr(OFS_REQ_EN, 32'hFFFF);
      rdchk("locked_en", OFS_REQ_EN, 32'h0);
      reg_lock <= 1'b0;
      $display("test lock done");
   endtask : t_lock
   task automatic t_irq();
      wr(OFS_RISE_EN, 32'h0001);
      wr(OFS_FALL_EN, 32'h0200);
      wr(OFS_REQ_EN, 32'h0001);
      @(posedge ref_clk);
      ext_irq_input[0] <= 1'b1;
      wait_irq(2'b01);
      ext_irq_input[9] <= 1'b1;
      repeat (10) @(posedge ref_clk);
      rdchk("no_rise9", OFS_FLAGS, 32'h0001);
      ext_irq_input[9] <= 1'b0;
      repeat (10) @(posedge ref_clk);
      rdchk("fall9", OFS_FLAGS, 32'h0201);
      chk("masked_irq", 32'h1, {30'h0, irq_vector});
      wr(OFS_FLAGS, 32'h0);
      rdchk("w0_keeps", OFS_FLAGS, 32'h0201);
      wr(OFS_FLAGS, 32'h0001);
      rdchk("w1_clears", OFS_FLAGS, 32'h0200);
      wr(OFS_REQ_EN, 32'h0200);
      chk("vector1", 32'h2, {30'h0, irq_vector});
      wr(OFS_FLAGS, 32'h0200);
      wr(OFS_FILT_EN, 32'h0001);
      wr(OFS_LIMIT_LO, 32'h3);
      wr(OFS_PRESC, 32'h1);
      @(posedge ref_clk);
      ext_irq_input[0] <= 1'b0;
      repeat (30) @(posedge ref_clk);
      ext_irq_input[0] <= 1'b1;
      repeat (2) @(posedge ref_clk);
      ext_irq_input[0] <= 1'b0;
      repeat (30) @(posedge ref_clk);
      rdchk("glitch", OFS_FLAGS, 32'h0);
      ext_irq_input[0] <= 1'b1;
      repeat (30) @(posedge ref_clk);
      rdchk("filtered", OFS_FLAGS, 32'h0001);
      wr(OFS_REQ_EN, 32'h0);
      $display("test irq done");
   endtask : t_irq
   // Watchdog against a hung run
   initial begin
      repeat (50000) @(posedge ref_clk);
      num_errors++;
      stop_test();
   end
   // Main sequence
   initial begin
      ref_clk = 1'b0;
      rstn = 1'b0;
      {psel, penable, pwrite, reg_lock} = 4'h0;
      paddr = 14'h0000;
      pwdata = 32'h0;
      pstrb = 4'hF;
      ext_level = 123'h12;
      short_low = '0;
      ext_irq_input = 16'h0000;
      repeat (8) @(posedge ref_clk);
      rstn <= 1'b1;
      t_regs();
      t_pads();
      t_port();
      t_lock();
      t_irq();
      stop_test();
   end
endmodule : pad_integration_unit_bench
`default_nettype wire

// *** verification/pad_world_model.sv ***
/*
 Far-side model of the device pads for the pad unit bench.
 Assumes the bench sets outside levels and any short to ground.
*/
`timescale 1ns/10ps
`default_nettype none
module pad_world_model (
   input wire logic [pad_integration_pkg::NUM_PADS-1:0] pad_level_out,
   input wire logic [pad_integration_pkg::NUM_PADS-1:0] pad_drive_en,
   input wire logic [pad_integration_pkg::NUM_PADS-1:0] ext_level,
   input wire logic [pad_integration_pkg::NUM_PADS-1:0] short_low,
   output logic [pad_integration_pkg::NUM_PADS-1:0] pad_level_in
);
   import pad_integration_pkg::*;
   // Driven pads follow the driver, others the outside; a short always wins
   assign pad_level_in = ((pad_level_out & pad_drive_en) | (ext_level & ~pad_drive_en))
                         & ~short_low;
endmodule : pad_world_model
`default_nettype wire

// *** verilog/pad_integration_unit.sv ***
/*
 Pad data, port and external interrupt unit behind an APB slave port.
 Assumes pads and interrupt pins are asynchronous to ref_clk and that an
 outside protection block drives reg_lock.
*/
// The implementer's own choice: the APB slave port.
// Behaviour
// RQ1 - Input data bit returns the sensed pad level when software reads it.
// RQ2 - Output pad drives the value last written to its output data bit.
// RQ3 - Input buffer on an output pad reads back the real pad level.
// RQ4 - Up to 123 pads, each with its own output and input data bit.
// RQ5 - Ports of up to 16 pads read or written in one access.
// RQ6 - Software sets every pad of a port to GPIO before port access.
// RQ7 - Sixteen interrupt inputs gathered onto two interrupt request lines.
// RQ8 - Sixteen programmable glitch filters ahead of edge detection.
// RQ9 - Rising and falling edge detection enabled separately per input.
// RQ10 - Pads 20 to 25 and 48 to 59 are input only.
// RQ11 - Access to a fully reserved address range ends with a bus error.
// RQ12 - Per-pad data registers byte accessible in aligned words.
// RQ13 - Listed configuration registers ignore writes while the lock is on.
// RQ14 - Reduced package keeps pad setup slots 0 to 78 only.
// RQ15 - Interrupt flag cleared only by writing one; zero leaves it.
// RQ16 - A set flag requests an interrupt only while enabled.
// RQ17 - All registers reset to defaults; writes act after the bus write.
// RQ18 - Each port bit maps to exactly one pad of that port.
`timescale 1ns/10ps
`default_nettype none
module pad_integration_unit #(
   parameter bit REDUCED_PKG = 1'b0,
   parameter logic [31:0] ID_ONE = 32'h12345678, // Arbitrary identity value
   parameter logic [31:0] ID_TWO = 32'h9ABCDEF0 // Arbitrary identity value
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pad_integration_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic reg_lock,
   input wire logic [pad_integration_pkg::NUM_PADS-1:0] pad_level_in,
   output logic [pad_integration_pkg::NUM_PADS-1:0] pad_level_out,
   output logic [pad_integration_pkg::NUM_PADS-1:0] pad_drive_en,
   input wire logic [pad_integration_pkg::NUM_EXT_IRQ_INPUT-1:0] ext_irq_input,
   output logic [1:0] irq_vector
);
   import pad_integration_pkg::*;

   // Pad has an output driver
   function automatic bit can_drive(input int n);
      can_drive = !((n >= IN_ONLY_A_LO && n <= IN_ONLY_A_HI) ||
                    (n >= IN_ONLY_B_LO && n <= IN_ONLY_B_HI));
   endfunction : can_drive

   // Pad setup slot is guarded by the write lock
   function automatic bit setup_locked(input int n);
      setup_locked = (n >= LOCK_A_LO && n <= LOCK_A_HI) ||
                     (n >= LOCK_B_LO && n <= LOCK_B_HI);
   endfunction : setup_locked

   // Byte-lane merge of a 16-bit half
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                           input logic [1:0] st);
      merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
   endfunction : merge16

   // Address within an inclusive range
   function automatic bit in_range(input logic [13:0] a, input logic [13:0] lo,
                                   input logic [13:0] hi);
      in_range = a >= lo && a <= hi;
   endfunction : in_range

   localparam int SETUP_PADS = REDUCED_PKG ? REDUCED_PADS : NUM_PADS;

   logic [15:0] setup_q [NUM_PADS];
   logic [NUM_PADS-1:0] out_q; // RQ4
   logic [31:0] sel_q [8];
   logic [3:0] limit_q [NUM_EXT_IRQ_INPUT];
   logic [3:0] presc_q;
   logic [NUM_EXT_IRQ_INPUT-1:0] flags_q, req_en_q, rise_en_q, fall_en_q, filt_en_q;
   logic [NUM_PADS-1:0] pad_s1_q, pad_s2_q, pad_s3_q, pad_stable_q;
   logic [NUM_EXT_IRQ_INPUT-1:0] irq_s1_q, irq_s2_q, irq_s3_q, irq_stable_q;
   logic [NUM_EXT_IRQ_INPUT-1:0] filt_q, filt_prev_q;
   logic [3:0] cnt_q [NUM_EXT_IRQ_INPUT];
   logic [3:0] pre_cnt_q;
   logic tick;
   logic [NUM_EXT_IRQ_INPUT-1:0] edge_ev;
   logic [NUM_PADS-1:0] pad_read;
   logic [13:0] a;
   logic [11:0] widx;
   logic hit, wr, wr_ok;
   logic [31:0] rdata;

   assign a = {paddr[13:2], 2'b00};
   assign widx = paddr[13:2];
   assign wr = psel && penable && pwrite && !pslverr;
   assign wr_ok = wr && !reg_lock;
   assign pready = 1'b1;

   // Level seen by software: sensed pad when its input buffer is on
   always_comb begin
      for (int n = 0; n < NUM_PADS; n++) begin
         pad_read[n] = setup_q[n][8] & pad_stable_q[n]; // RQ1 RQ3
      end
   end

   // Three-stage pad synchroniser, level taken once stages two and three agree
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pad_s1_q <= '0;
         pad_s2_q <= '0;
         pad_s3_q <= '0;
         pad_stable_q <= '0;
      end else begin
         pad_s1_q <= pad_level_in;
         pad_s2_q <= pad_s1_q;
         pad_s3_q <= pad_s2_q;
         for (int n = 0; n < NUM_PADS; n++) begin
            if (pad_s2_q[n] == pad_s3_q[n]) begin
               pad_stable_q[n] <= pad_s3_q[n];
            end
         end
      end
   end

   // Pad drivers follow the output data bit in GPIO mode with the buffer on
   always_comb begin
      for (int n = 0; n < NUM_PADS; n++) begin
         pad_level_out[n] = out_q[n]; // RQ2
         pad_drive_en[n] = can_drive(n) && setup_q[n][9] &&
                           (setup_q[n][11:10] == PA_GPIO); // RQ10
      end
   end

   // Address decode: mapped words answer, fully reserved space errors
   always_comb begin
      hit = (a == OFS_ID_ONE) || (a == OFS_ID_TWO) || (a == OFS_FLAGS) ||
            (a == OFS_REQ_EN) || (a == OFS_RISE_EN) || (a == OFS_FALL_EN) ||
            (a == OFS_FILT_EN) || (a == OFS_PRESC) ||
            in_range(a, OFS_SEL_LO, OFS_SEL_HI) || in_range(a, OFS_OUTV_LO, OFS_OUTV_HI) ||
            in_range(a, OFS_INV_LO, OFS_INV_HI) || in_range(a, OFS_PORTO_LO, OFS_PORTO_HI) ||
            in_range(a, OFS_PORTI_LO, OFS_PORTI_HI) ||
            in_range(a, OFS_MASKED_LO, OFS_MASKED_HI) ||
            in_range(a, OFS_LIMIT_LO, OFS_LIMIT_HI) ||
            (in_range(a, OFS_SETUP_LO, OFS_SETUP_HI) &&
             (int'(widx - OFS_SETUP_LO[13:2]) * 2 < SETUP_PADS)); // RQ14
      pslverr = psel && penable && !hit; // RQ11
   end

   // Read data mux
   always_comb begin
      int b;
      b = 0;
      rdata = '0;
      if (a == OFS_ID_ONE) begin
         rdata = ID_ONE;
      end else if (a == OFS_ID_TWO) begin
         rdata = ID_TWO;
      end else if (a == OFS_FLAGS) begin
         rdata[NUM_EXT_IRQ_INPUT-1:0] = flags_q;
      end else if (a == OFS_REQ_EN) begin
         rdata[NUM_EXT_IRQ_INPUT-1:0] = req_en_q;
      end else if (a == OFS_RISE_EN) begin
         rdata[NUM_EXT_IRQ_INPUT-1:0] = rise_en_q;
      end else if (a == OFS_FALL_EN) begin
         rdata[NUM_EXT_IRQ_INPUT-1:0] = fall_en_q;
      end else if (a == OFS_FILT_EN) begin
         rdata[NUM_EXT_IRQ_INPUT-1:0] = filt_en_q;
      end else if (a == OFS_PRESC) begin
         rdata[3:0] = presc_q;
      end else if (in_range(a, OFS_SETUP_LO, OFS_SETUP_HI)) begin
         b = int'(widx - OFS_SETUP_LO[13:2]) * 2;
         if (b < SETUP_PADS) rdata[15:0] = setup_q[b];
         if (b + 1 < SETUP_PADS) rdata[31:16] = setup_q[b+1];
      end else if (in_range(a, OFS_SEL_LO, OFS_SEL_HI)) begin
         rdata = sel_q[widx[2:0]];
      end else if (in_range(a, OFS_OUTV_LO, OFS_OUTV_HI) ||
                   in_range(a, OFS_INV_LO, OFS_INV_HI)) begin
         b = int'(widx[4:0]) * 4;
         for (int k = 0; k < 4; k++) begin
            if (b + k < NUM_PADS) begin
               rdata[8*k] = a[11] ? pad_read[b+k] : out_q[b+k]; // RQ12
            end
         end
      end else if (in_range(a, OFS_PORTO_LO, OFS_PORTO_HI) ||
                   in_range(a, OFS_PORTI_LO, OFS_PORTI_HI)) begin
         b = int'(widx[1:0]) * 2 * PORT_W;
         for (int k = 0; k < 2 * PORT_W; k++) begin
            if (b + k < NUM_PADS) begin
               rdata[k] = a[6] ? pad_read[b+k] : out_q[b+k]; // RQ5 RQ18
            end
         end
      end else if (in_range(a, OFS_LIMIT_LO, OFS_LIMIT_HI)) begin
         rdata[3:0] = limit_q[widx[3:0]];
      end
   end

   // Read data register, loaded in the setup cycle of a read
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rdata;
      end
   end

   // Pad setup slots, two per word, byte lanes honoured
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         for (int n = 0; n < NUM_PADS; n++) setup_q[n] <= SETUP_RST;
      end else if (wr && in_range(a, OFS_SETUP_LO, OFS_SETUP_HI)) begin
         for (int k = 0; k < 2; k++) begin
            int n;
            n = int'(widx - OFS_SETUP_LO[13:2]) * 2 + k;
            if (n < SETUP_PADS && !(reg_lock && setup_locked(n))) begin // RQ13 RQ14
               setup_q[n] <= merge16(setup_q[n], pwdata[16*k +: 16], pstrb[2*k +: 2]);
            end
         end
      end
   end

   // Output data: per pad bytes, whole ports, and masked port writes
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         out_q <= '0;
      end else if (wr) begin
         if (in_range(a, OFS_OUTV_LO, OFS_OUTV_HI)) begin
            for (int k = 0; k < 4; k++) begin
               if (int'(widx[4:0]) * 4 + k < NUM_PADS && pstrb[k]) begin
                  out_q[int'(widx[4:0]) * 4 + k] <= pwdata[8*k]; // RQ2 RQ12
               end
            end
         end else if (in_range(a, OFS_PORTO_LO, OFS_PORTO_HI)) begin
            for (int k = 0; k < 2 * PORT_W; k++) begin
               if (int'(widx[1:0]) * 2 * PORT_W + k < NUM_PADS && pstrb[k/8]) begin
                  out_q[int'(widx[1:0]) * 2 * PORT_W + k] <= pwdata[k]; // RQ5 RQ18
               end
            end
         end else if (in_range(a, OFS_MASKED_LO, OFS_MASKED_HI)) begin
            for (int k = 0; k < PORT_W; k++) begin
               if (int'(widx[2:0]) * PORT_W + k < NUM_PADS && pwdata[PORT_W+k]) begin
                  out_q[int'(widx[2:0]) * PORT_W + k] <= pwdata[k]; // RQ18
               end
            end
         end
      end
   end

   // Interrupt configuration registers, all under the write lock
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         req_en_q <= EXT_IRQ_INPUT_RST;
         rise_en_q <= EXT_IRQ_INPUT_RST;
         fall_en_q <= EXT_IRQ_INPUT_RST;
         filt_en_q <= EXT_IRQ_INPUT_RST;
         presc_q <= PRESC_RST;
         for (int i = 0; i < 8; i++) sel_q[i] <= SEL_RST;
         for (int i = 0; i < NUM_EXT_IRQ_INPUT; i++) limit_q[i] <= LIMIT_RST;
      end else if (wr_ok) begin // RQ13 RQ17
         if (a == OFS_REQ_EN) req_en_q <= pwdata[NUM_EXT_IRQ_INPUT-1:0];
         if (a == OFS_RISE_EN) rise_en_q <= pwdata[NUM_EXT_IRQ_INPUT-1:0];
         if (a == OFS_FALL_EN) fall_en_q <= pwdata[NUM_EXT_IRQ_INPUT-1:0];
         if (a == OFS_FILT_EN) filt_en_q <= pwdata[NUM_EXT_IRQ_INPUT-1:0];
         if (a == OFS_PRESC) presc_q <= pwdata[3:0];
         if (in_range(a, OFS_SEL_LO, OFS_SEL_HI)) sel_q[widx[2:0]] <= pwdata;
         if (in_range(a, OFS_LIMIT_LO, OFS_LIMIT_HI)) limit_q[widx[3:0]] <= pwdata[3:0];
      end
   end

   // Interrupt pin synchroniser, same three-stage agreement as the pads
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         irq_s1_q <= '0;
         irq_s2_q <= '0;
         irq_s3_q <= '0;
         irq_stable_q <= '0;
      end else begin
         irq_s1_q <= ext_irq_input;
         irq_s2_q <= irq_s1_q;
         irq_s3_q <= irq_s2_q;
         for (int i = 0; i < NUM_EXT_IRQ_INPUT; i++) begin
            if (irq_s2_q[i] == irq_s3_q[i]) irq_stable_q[i] <= irq_s3_q[i];
         end
      end
   end

   // Filter time base: one tick every prescaler plus one clocks
   assign tick = (pre_cnt_q == presc_q);
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pre_cnt_q <= '0;
      end else begin
         pre_cnt_q <= tick ? 4'h0 : pre_cnt_q + 4'h1;
      end
   end

   // Glitch filters: a new level must persist beyond the limit in ticks
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         filt_q <= '0;
         filt_prev_q <= '0;
         for (int i = 0; i < NUM_EXT_IRQ_INPUT; i++) cnt_q[i] <= 4'h0;
      end else begin
         filt_prev_q <= filt_q;
         for (int i = 0; i < NUM_EXT_IRQ_INPUT; i++) begin
            if (!filt_en_q[i] || irq_stable_q[i] == filt_q[i]) begin
               filt_q[i] <= irq_stable_q[i];
               cnt_q[i] <= 4'h0;
            end else if (tick) begin
               if (cnt_q[i] >= limit_q[i]) begin
                  filt_q[i] <= irq_stable_q[i]; // RQ8
                  cnt_q[i] <= 4'h0;
               end else begin
                  cnt_q[i] <= cnt_q[i] + 4'h1;
               end
            end
         end
      end
   end

   // Edge events on the filtered level
   assign edge_ev = (rise_en_q & filt_q & ~filt_prev_q) |
                    (fall_en_q & ~filt_q & filt_prev_q); // RQ9

   // Sticky flags, a new event beats a same-cycle write-one clear
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         flags_q <= EXT_IRQ_INPUT_RST;
      end else if (wr && a == OFS_FLAGS) begin
         flags_q <= (flags_q & ~pwdata[NUM_EXT_IRQ_INPUT-1:0]) | edge_ev; // RQ15
      end else begin
         flags_q <= flags_q | edge_ev;
      end
   end

   // Two request lines, each gathering eight enabled flags
   always_comb begin
      for (int v = 0; v < 2; v++) begin
         irq_vector[v] = |(flags_q[EXT_IRQ_INPUT_PER_VECTOR*v +: EXT_IRQ_INPUT_PER_VECTOR] &
                           req_en_q[EXT_IRQ_INPUT_PER_VECTOR*v +: EXT_IRQ_INPUT_PER_VECTOR]); // RQ7 RQ16
      end
   end
endmodule : pad_integration_unit
`default_nettype wire
